// ### src/fpms_hold_det.sv
// fpms_hold_det.sv: fires one pulse once a level has been held for a number of ticks
// assumes: level and tick come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module fpms_hold_det #(
  parameter int HOLD_TICKS = 1001
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // level to watch and slow tick
  input  wire logic level_i,
  input  wire logic tick_i,
  // one-cycle pulse per hold
  output logic      fire_o
);

  logic [$clog2(HOLD_TICKS+1)-1:0] cnt_reg;
  logic                            done_reg;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
      fire_o   <= 1'b0;
    end
    else
    begin
      fire_o <= 1'b0;
      if (!level_i)
      begin
        cnt_reg  <= '0;
        done_reg <= 1'b0;
      end
      else if (tick_i && !done_reg)
      begin
        if (cnt_reg == ($clog2(HOLD_TICKS+1))'(HOLD_TICKS - 1))
        begin
          done_reg <= 1'b1;
          fire_o   <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### src/fpms_idle_timer.sv
// fpms_idle_timer.sv: pulses once after a restart when no further restart came for a number of ticks
// assumes: restart, cancel and tick come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module fpms_idle_timer #(
  parameter int IDLE_TICKS = 2001
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic restart_i,
  input  wire logic cancel_i,
  input  wire logic tick_i,
  // one-cycle pulse at expiry
  output logic      expire_o
);

  logic [$clog2(IDLE_TICKS+1)-1:0] cnt_reg;
  logic                            armed_reg;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_reg   <= '0;
      armed_reg <= 1'b0;
      expire_o  <= 1'b0;
    end
    else
    begin
      expire_o <= 1'b0;
      if (restart_i)
      begin
        cnt_reg   <= '0;
        armed_reg <= 1'b1;
      end
      else if (cancel_i)
        armed_reg <= 1'b0;
      else if (armed_reg && tick_i)
      begin
        if (cnt_reg == ($clog2(IDLE_TICKS+1))'(IDLE_TICKS - 1))
        begin
          armed_reg <= 1'b0;
          expire_o  <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### src/fpms_pkg.sv
// fpms_pkg.sv: types shared by the front-panel sequencer modules
// assumes: mode codes are written here as literals; fpms_regs.svh holds the other numeric values
package fpms_pkg;

  typedef enum logic [3:0] {
    MODE_PROTECT = 4'h0,
    MODE_MANUAL  = 4'h1,
    MODE_LEVEL0  = 4'h2,
    MODE_LEVEL1  = 4'h3,
    MODE_LEVEL2  = 4'h4,
    MODE_SETUP   = 4'h5,
    MODE_EXPAND  = 4'h6,
    MODE_OPTION  = 4'h7,
    MODE_CALIB   = 4'h8
  } fpms_mode_t;

  // raw front-panel keys, high while pressed
  typedef struct packed {
    logic menu;
    logic auto_manual_key;
    logic mode;
    logic up;
    logic down;
  } fpms_keys_t;

  // state shown to the display and the control loop
  typedef struct packed {
    fpms_mode_t mode;
    logic       menu_open;
    fpms_mode_t menu_sel;
    logic       control_reset;
    logic [3:0] param_idx;
  } fpms_status_t;

endpackage

// ### src/fpms_regs.svh
// fpms_regs.svh: timing counts, field codes and table values of the front-panel sequencer
// assumes: included by bare name from the top design module only
`ifndef FPMS_REGS_SVH
`define FPMS_REGS_SVH

// timing: the system clock period and a 1 ms slow tick
`define FPMS_CLK_PERIOD_NS   25
`define FPMS_TICK_PERIOD_NS  1000000
`define FPMS_TICK_CYCLES     ((`FPMS_TICK_PERIOD_NS + `FPMS_CLK_PERIOD_NS - 1) / `FPMS_CLK_PERIOD_NS)
`define FPMS_TICK_MS         1
// least hold of a key and least idle time before a commit, in ms
`define FPMS_HOLD_MS         1000
`define FPMS_IDLE_MS         2000
// one extra tick covers the unknown phase of the tick at the first press
`define FPMS_HOLD_TICKS      ((`FPMS_HOLD_MS + `FPMS_TICK_MS - 1) / `FPMS_TICK_MS + 1)
`define FPMS_IDLE_TICKS      ((`FPMS_IDLE_MS + `FPMS_TICK_MS - 1) / `FPMS_TICK_MS + 1)

// protection level: how far up from level 0 the menu modes are locked
`define FPMS_PROT_NONE       2'h0
`define FPMS_PROT_LV0        2'h1
`define FPMS_PROT_LV1        2'h2
`define FPMS_PROT_LV2        2'h3

// input type selected in the configuration
`define FPMS_IN_TC           2'h0
`define FPMS_IN_PT           2'h1
`define FPMS_IN_CUR          2'h2
`define FPMS_IN_VOLT         2'h3

// calibration item bits
`define FPMS_CAL_ITEMS       7
`define FPMS_CAL_TC_MASK     7'h03
`define FPMS_CAL_PT_MASK     7'h04
`define FPMS_CAL_CUR_MASK    7'h08
`define FPMS_CAL_VOLT_MASK   7'h30
`define FPMS_CAL_XFER_MASK   7'h40

// last parameter index of each mode except manual
`define FPMS_LAST_PROTECT    4'h1
`define FPMS_LAST_LEVEL0     4'h4
`define FPMS_LAST_LEVEL1     4'hd
`define FPMS_LAST_LEVEL2     4'hc
`define FPMS_LAST_SETUP      4'hf
`define FPMS_LAST_EXPAND     4'hc
`define FPMS_LAST_OPTION     4'hb
`define FPMS_LAST_CALIB      4'h7

`endif

// ### src/fpms_top.sv
// fpms_top.sv: front-panel mode and parameter sequencer of a process controller
// assumes: keys are raw pins; configuration inputs come from logic on ref_clk_i
//
// Contract
// - menu opens only after menu key held one second, not in protect/manual
// - an opened menu first shows the mode active before it
// - protected modes cannot be selected
// - protection up to level 1 keeps the menu shut
// - levels 0 to 2 are entered with control still running
// - setup, expansion, option, calibration put control in reset, outputs off
// - leaving those configuration modes releases the control reset
// - auto/manual plus mode key held one second toggles protect and level 0
// - auto/manual key held one second in levels 0 to 2 enters manual
// - mode key steps parameters with wrap, except in manual
// - an edit commits after two idle seconds or on a mode key press
// - a change of mode commits pending edits of the old mode
// - input calibration acts only on the selected input type
// - transfer output calibration needs the transfer option unit
// - four input groups; thermocouple and voltage have two items each
// - items held provisional; final commit only when all freshly calibrated
// - committing calibration also stores a user-calibrated flag
// - each commit replaces stored calibration; factory values are not restored
// - manipulated variable changes only in manual mode
`timescale 1ns/1ps
`default_nettype none
`include "fpms_regs.svh"
module fpms_top #(
  parameter int TICK_DIV   = `FPMS_TICK_CYCLES,
  parameter int HOLD_TICKS = `FPMS_HOLD_TICKS,
  parameter int IDLE_TICKS = `FPMS_IDLE_TICKS
) (
  // clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  // front-panel keys, raw pins
  input  wire fpms_pkg::fpms_keys_t keys_i,
  // configuration
  input  wire logic [1:0]          prot_level_i,
  input  wire logic                option_present_i,
  input  wire logic                xfer_present_i,
  input  wire logic [1:0]          input_type_i,
  // calibration strobes
  input  wire logic                cal_item_stb_i,
  input  wire logic [2:0]          cal_item_i,
  input  wire logic                cal_commit_req_i,
  // status
  output fpms_pkg::fpms_status_t   status_o,
  // parameter editing
  output logic                     param_inc_o,
  output logic                     param_dec_o,
  output logic                     param_commit_o,
  // manipulated variable, manual only
  output logic                     mv_inc_o,
  output logic                     mv_dec_o,
  // calibration
  output logic [`FPMS_CAL_ITEMS-1:0] cal_prov_o,
  output logic                     cal_commit_o,
  output logic                     cal_done_o
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic is_cfg(input fpms_pkg::fpms_mode_t m);
    is_cfg = (m == fpms_pkg::MODE_SETUP) || (m == fpms_pkg::MODE_EXPAND) ||
             (m == fpms_pkg::MODE_OPTION) || (m == fpms_pkg::MODE_CALIB);
  endfunction

  function automatic logic is_level(input fpms_pkg::fpms_mode_t m);
    is_level = (m == fpms_pkg::MODE_LEVEL0) || (m == fpms_pkg::MODE_LEVEL1) ||
               (m == fpms_pkg::MODE_LEVEL2);
  endfunction

  // a menu entry may be chosen when not locked and, for option, when fitted
  function automatic logic allowed(input fpms_pkg::fpms_mode_t m, input logic [1:0] prot,
                                   input logic opt);
    logic [3:0] lock;
    lock = 4'h2 + {2'h0, prot};
    allowed = (m >= fpms_pkg::MODE_LEVEL0) && (m <= fpms_pkg::MODE_CALIB) &&
              (4'(m) >= lock) && ((m != fpms_pkg::MODE_OPTION) || opt);
  endfunction

  // next allowed menu entry in one direction, wrapping over the menu
  function automatic fpms_pkg::fpms_mode_t step_sel(input fpms_pkg::fpms_mode_t cur,
                                                    input logic up, input logic [1:0] prot,
                                                    input logic opt);
    logic [3:0] s;
    step_sel = cur;
    s = 4'(cur);
    for (int i = 0; i < 7; i++)
    begin
      if (up)
        s = (s == 4'h8) ? 4'h2 : s + 4'h1;
      else
        s = (s == 4'h2) ? 4'h8 : s - 4'h1;
      if (allowed(fpms_pkg::fpms_mode_t'(s), prot, opt) && (step_sel == cur))
        step_sel = fpms_pkg::fpms_mode_t'(s);
    end
  endfunction

  function automatic logic [3:0] last_param(input fpms_pkg::fpms_mode_t m);
    unique case (m)
      fpms_pkg::MODE_PROTECT: last_param = `FPMS_LAST_PROTECT;
      fpms_pkg::MODE_LEVEL0:  last_param = `FPMS_LAST_LEVEL0;
      fpms_pkg::MODE_LEVEL1:  last_param = `FPMS_LAST_LEVEL1;
      fpms_pkg::MODE_LEVEL2:  last_param = `FPMS_LAST_LEVEL2;
      fpms_pkg::MODE_SETUP:   last_param = `FPMS_LAST_SETUP;
      fpms_pkg::MODE_EXPAND:  last_param = `FPMS_LAST_EXPAND;
      fpms_pkg::MODE_OPTION:  last_param = `FPMS_LAST_OPTION;
      fpms_pkg::MODE_CALIB:   last_param = `FPMS_LAST_CALIB;
      default:                last_param = 4'h0;
    endcase
  endfunction

  // items that must be freshly calibrated for the present configuration
  function automatic logic [`FPMS_CAL_ITEMS-1:0] cal_req(input logic [1:0] itype,
                                                         input logic xfer);
    unique case (itype)
      `FPMS_IN_TC:   cal_req = `FPMS_CAL_TC_MASK;
      `FPMS_IN_PT:   cal_req = `FPMS_CAL_PT_MASK;
      `FPMS_IN_CUR:  cal_req = `FPMS_CAL_CUR_MASK;
      `FPMS_IN_VOLT: cal_req = `FPMS_CAL_VOLT_MASK;
    endcase
    if (xfer)
      cal_req = cal_req | `FPMS_CAL_XFER_MASK;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // key synchronisers, tick and edges

  fpms_pkg::fpms_keys_t key_meta_reg;
  fpms_pkg::fpms_keys_t key_sync_reg;
  fpms_pkg::fpms_keys_t key_last_reg;
  logic [$clog2(TICK_DIV+1)-1:0] div_reg;
  logic                          tick;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      key_meta_reg <= '0;
      key_sync_reg <= '0;
      key_last_reg <= '0;
    end
    else
    begin
      key_meta_reg <= keys_i;
      key_sync_reg <= key_meta_reg;
      key_last_reg <= key_sync_reg;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      div_reg <= '0;
    else if (div_reg == ($clog2(TICK_DIV+1))'(TICK_DIV - 1))
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end

  assign tick = (div_reg == ($clog2(TICK_DIV+1))'(TICK_DIV - 1));

  logic am_held;
  logic mode_e;
  logic up_e;
  logic down_e;
  logic menu_fire;
  logic am_fire;
  logic prot_fire;
  logic idle_fire;

  assign am_held = key_sync_reg.auto_manual_key;
  assign mode_e  = key_sync_reg.mode && !key_last_reg.mode && !am_held;
  assign up_e    = key_sync_reg.up && !key_last_reg.up;
  assign down_e  = key_sync_reg.down && !key_last_reg.down;

  // the three timed holds; a combination hold keeps the single-key hold quiet
  fpms_hold_det #(.HOLD_TICKS(HOLD_TICKS)) u_menu_hold (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .level_i   (key_sync_reg.menu),
    .tick_i    (tick),
    .fire_o    (menu_fire)
  );

  fpms_hold_det #(.HOLD_TICKS(HOLD_TICKS)) u_am_hold (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .level_i   (am_held && !key_sync_reg.mode),
    .tick_i    (tick),
    .fire_o    (am_fire)
  );

  fpms_hold_det #(.HOLD_TICKS(HOLD_TICKS)) u_prot_hold (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .level_i   (am_held && key_sync_reg.mode),
    .tick_i    (tick),
    .fire_o    (prot_fire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode and menu

  fpms_pkg::fpms_mode_t mode_reg;
  fpms_pkg::fpms_mode_t mode_next;
  fpms_pkg::fpms_mode_t sel_reg;
  fpms_pkg::fpms_mode_t sel_next;
  logic                 menu_reg;
  logic                 menu_next;
  logic                 ctl_reset_reg;
  logic                 mode_chg;

  always_comb
  begin
    mode_next = mode_reg;
    sel_next  = sel_reg;
    menu_next = menu_reg;
    if (prot_fire)
    begin
      menu_next = 1'b0;
      mode_next = (mode_reg == fpms_pkg::MODE_PROTECT) ? fpms_pkg::MODE_LEVEL0
                                                       : fpms_pkg::MODE_PROTECT;
    end
    else if (am_fire && !menu_reg)
    begin
      if (is_level(mode_reg))
        mode_next = fpms_pkg::MODE_MANUAL;
      else if (mode_reg == fpms_pkg::MODE_MANUAL)
        mode_next = fpms_pkg::MODE_LEVEL0;
    end
    else if (menu_reg)
    begin
      if (up_e)
        sel_next = step_sel(sel_reg, 1'b1, prot_level_i, option_present_i);
      else if (down_e)
        sel_next = step_sel(sel_reg, 1'b0, prot_level_i, option_present_i);
      else if (mode_e)
      begin
        menu_next = 1'b0;
        if (allowed(sel_reg, prot_level_i, option_present_i))
          mode_next = sel_reg;
      end
    end
    else if (menu_fire && (mode_reg != fpms_pkg::MODE_PROTECT) &&
             (mode_reg != fpms_pkg::MODE_MANUAL) &&
             (prot_level_i < `FPMS_PROT_LV1))
    begin
      menu_next = 1'b1;
      sel_next  = mode_reg;
    end
  end

  assign mode_chg = (mode_next != mode_reg);

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_reg      <= fpms_pkg::MODE_LEVEL0;
      sel_reg       <= fpms_pkg::MODE_LEVEL0;
      menu_reg      <= 1'b0;
      ctl_reset_reg <= 1'b0;
    end
    else
    begin
      mode_reg      <= mode_next;
      sel_reg       <= sel_next;
      menu_reg      <= menu_next;
      ctl_reset_reg <= is_cfg(mode_next);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameter stepping, edits and commits

  logic [3:0] param_reg;
  logic       pending_reg;
  logic       edit;
  logic       commit_now;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      param_reg <= 4'h0;
    else if (mode_chg)
      param_reg <= 4'h0;
    else if (mode_e && !menu_reg && (mode_reg != fpms_pkg::MODE_MANUAL))
      param_reg <= (param_reg >= last_param(mode_reg)) ? 4'h0 : param_reg + 4'h1;
  end

  assign edit = (up_e || down_e) && !menu_reg && !prot_fire && !am_fire &&
                (mode_reg != fpms_pkg::MODE_MANUAL);

  fpms_idle_timer #(.IDLE_TICKS(IDLE_TICKS)) u_idle (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .restart_i (edit),
    .cancel_i  (commit_now),
    .tick_i    (tick),
    .expire_o  (idle_fire)
  );

  assign commit_now = pending_reg &&
                      (idle_fire || (mode_e && !menu_reg) || mode_chg);

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pending_reg    <= 1'b0;
      param_commit_o <= 1'b0;
      param_inc_o    <= 1'b0;
      param_dec_o    <= 1'b0;
    end
    else
    begin
      param_commit_o <= commit_now;
      param_inc_o    <= edit && up_e;
      param_dec_o    <= edit && !up_e;
      // a new edit in the commit cycle keeps the value pending
      if (edit)
        pending_reg <= 1'b1;
      else if (commit_now)
        pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mv_inc_o <= 1'b0;
      mv_dec_o <= 1'b0;
    end
    else
    begin
      mv_inc_o <= up_e && (mode_reg == fpms_pkg::MODE_MANUAL);
      mv_dec_o <= down_e && (mode_reg == fpms_pkg::MODE_MANUAL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user calibration

  logic [`FPMS_CAL_ITEMS-1:0] req_mask;
  logic                       cal_ready;

  assign req_mask  = cal_req(input_type_i, xfer_present_i);
  assign cal_ready = ((cal_prov_o & req_mask) == req_mask);

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cal_prov_o   <= '0;
      cal_commit_o <= 1'b0;
      cal_done_o   <= 1'b0;
    end
    else
    begin
      cal_commit_o <= 1'b0;
      if (mode_reg != fpms_pkg::MODE_CALIB)
        cal_prov_o <= '0;
      else if (cal_commit_req_i && cal_ready)
      begin
        // the store overwrites earlier data; factory values are gone
        cal_commit_o <= 1'b1;
        cal_done_o   <= 1'b1;
        cal_prov_o   <= '0;
        // an item strobed in the commit cycle stays provisional for the next store
        if (cal_item_stb_i && (int'(cal_item_i) < `FPMS_CAL_ITEMS) && req_mask[cal_item_i])
          cal_prov_o[cal_item_i] <= 1'b1;
      end
      else if (cal_item_stb_i && (int'(cal_item_i) < `FPMS_CAL_ITEMS) && req_mask[cal_item_i])
        cal_prov_o[cal_item_i] <= 1'b1;
    end
  end

  assign status_o = '{mode:          mode_reg,
                      menu_open:     menu_reg,
                      menu_sel:      sel_reg,
                      control_reset: ctl_reset_reg,
                      param_idx:     param_reg};

  ////////////////////////////////////////////////////////////////////////////
  // checks

  localparam int MIN_HOLD_CYC = (HOLD_TICKS - 1) * TICK_DIV;
  logic [31:0] menu_held_cyc;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      menu_held_cyc <= 32'h0;
    else if (!key_sync_reg.menu)
      menu_held_cyc <= 32'h0;
    else if (menu_held_cyc != 32'hffffffff)
      menu_held_cyc <= menu_held_cyc + 32'h1;
  end

  a_menu_hold_time: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(menu_reg) |-> ($past(menu_held_cyc, 2) >= 32'(MIN_HOLD_CYC)))
    else $error("menu opened before the key was held long enough");

  a_menu_first_sel: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(menu_reg) |-> (sel_reg == $past(mode_reg)) && (mode_reg == $past(mode_reg)))
    else $error("menu did not open on the previous mode");

  a_menu_prot_shut: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($past(prot_level_i) >= `FPMS_PROT_LV1) |-> !$rose(menu_reg))
    else $error("menu opened while locked up to level 1");

  a_menu_sel_taken: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($fell(menu_reg) && $changed(mode_reg) && (mode_reg != fpms_pkg::MODE_PROTECT))
    |-> (mode_reg == $past(sel_reg)) && $past(allowed(sel_reg, prot_level_i, option_present_i)))
    else $error("protected mode was selected");

  a_cfg_reset_out: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    status_o.control_reset == is_cfg(mode_reg))
    else $error("control reset disagrees with the mode");

  a_manual_entry: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (mode_reg == fpms_pkg::MODE_MANUAL) && $changed(mode_reg)
    |-> is_level($past(mode_reg)) && $past(am_fire))
    else $error("manual entered without a hold from levels 0 to 2");

  a_mv_manual_only: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (mv_inc_o || mv_dec_o) |-> ($past(mode_reg) == fpms_pkg::MODE_MANUAL) && !param_inc_o)
    else $error("manipulated variable changed outside manual");

  a_mode_chg_commit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($past(pending_reg) && $changed(mode_reg)) |-> param_commit_o ##1 !param_commit_o)
    else $error("pending edit not committed on a mode change");

  a_cal_commit_all: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cal_commit_o |-> ($past(cal_prov_o & req_mask) == $past(req_mask)) && cal_done_o)
    else $error("calibration committed before every item was done");

  a_prot_toggle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    prot_fire && (mode_reg == fpms_pkg::MODE_PROTECT) |=> (mode_reg == fpms_pkg::MODE_LEVEL0))
    else $error("protect mode did not return to level 0");

endmodule
`default_nettype wire

// ### test/fpms_op.sv
// fpms_op.sv: operator model pressing the front-panel keys
// assumes: tb calls push; keys change at rising edges
`timescale 1ns/1ps
`default_nettype none
module fpms_op (
  // clock
  input  wire logic               ref_clk_i,
  // keys to the panel
  output var fpms_pkg::fpms_keys_t keys_o
);
  initial keys_o = '0;
  // press a key set for n cycles, then release every key
  task automatic push(input logic [4:0] k, input int n);
    @(posedge ref_clk_i);
    keys_o <= k;
    repeat (n) @(posedge ref_clk_i);
    keys_o <= '0;
  endtask
endmodule
`default_nettype wire

// ### test/tb.sv
// tb.sv: self-checking bench of the front-panel sequencer
// assumes: shortened tick, hold and idle counts; fpms_op plays the operator
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                   ref_clk_i;
  logic                   rst_i;
  logic [1:0]             prot;
  logic                   opt;
  fpms_pkg::fpms_keys_t   keys;
  fpms_pkg::fpms_status_t st;
  logic                   inc;
  logic                   cmt;
  logic                   dec, mvi, mvd, ccmt, cdone;
  logic                   xfer, cstb, creq;
  logic [1:0]             itype;
  logic [2:0]             citem;
  logic [6:0]             cprov;
  int                     n_dec = 0, n_mvi = 0, n_mvd = 0, n_cc = 0;
  int                     miscompares = 0;
  int                     samples_checked = 0;
  int                     n_inc = 0;
  int                     n_cmt = 0;
  // keys, hold cycles, mode, menu open, menu choice, control reset
  typedef struct packed {logic [4:0] k; logic [7:0] n; logic [3:0] m; logic o; logic [3:0] s; logic r;} fpms_row_t;
  fpms_row_t rows [12] = '{
    '{5'h08, 8'd30, 4'h1, 1'b0, 4'h0, 1'b0}, '{5'h08, 8'd30, 4'h2, 1'b0, 4'h0, 1'b0},
    '{5'h0c, 8'd30, 4'h0, 1'b0, 4'h0, 1'b0}, '{5'h0c, 8'd30, 4'h2, 1'b0, 4'h0, 1'b0},
    '{5'h10, 8'd30, 4'h2, 1'b1, 4'h2, 1'b0}, '{5'h02, 8'd3, 4'h2, 1'b1, 4'h3, 1'b0},
    '{5'h02, 8'd3, 4'h2, 1'b1, 4'h4, 1'b0}, '{5'h02, 8'd3, 4'h2, 1'b1, 4'h5, 1'b0},
    '{5'h04, 8'd3, 4'h5, 1'b0, 4'h0, 1'b1}, '{5'h10, 8'd30, 4'h5, 1'b1, 4'h5, 1'b1},
    '{5'h01, 8'd3, 4'h5, 1'b1, 4'h4, 1'b1}, '{5'h04, 8'd3, 4'h4, 1'b0, 4'h0, 1'b0}};

  fpms_top #(.TICK_DIV(4), .HOLD_TICKS(5), .IDLE_TICKS(8)) DUT (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .keys_i(keys), .prot_level_i(prot), .option_present_i(opt),
    .xfer_present_i(xfer), .input_type_i(itype), .cal_item_stb_i(cstb), .cal_item_i(citem),
    .cal_commit_req_i(creq), .status_o(st), .param_inc_o(inc), .param_dec_o(dec), .param_commit_o(cmt),
    .mv_inc_o(mvi), .mv_dec_o(mvd), .cal_prov_o(cprov), .cal_commit_o(ccmt), .cal_done_o(cdone));
  fpms_op op (.ref_clk_i(ref_clk_i), .keys_o(keys));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i)
  begin
    n_inc <= n_inc + int'(inc === 1'b1);
    n_cmt <= n_cmt + int'(cmt === 1'b1);
    n_dec <= n_dec + int'(dec === 1'b1);
    n_mvi <= n_mvi + int'(mvi === 1'b1);
    n_mvd <= n_mvd + int'(mvd === 1'b1);
    n_cc  <= n_cc + int'(ccmt === 1'b1);
  end

  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic step(input logic [4:0] k, input int n);
    op.push(k, n);
    repeat (8) @(posedge ref_clk_i);
  endtask

  // one-cycle calibration strobe and/or commit request
  task automatic cal_pulse(input logic s, input logic r, input logic [2:0] i);
    @(posedge ref_clk_i);
    cstb  <= s;
    creq  <= r;
    citem <= i;
    @(posedge ref_clk_i);
    cstb <= 1'b0;
    creq <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    rst_i = 1'b1;
    prot = 2'h0;
    opt = 1'b1;
    {xfer, itype, cstb, creq, citem} = '0;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    chk({st.mode, st.menu_open, st.control_reset, st.param_idx}, {4'h2, 1'b0, 1'b0, 4'h0});
    foreach (rows[i])
    begin
      step(rows[i].k, 32'(rows[i].n));
      chk({st.mode, st.menu_open, st.control_reset, 4'h0}, {rows[i].m, rows[i].o, rows[i].r, 4'h0});
      if (rows[i].o)
        chk({6'h0, st.menu_sel}, {6'h0, rows[i].s});
    end
    // a long hold toggles once only
    step(5'h08, 100);
    chk({6'h0, st.mode}, {6'h0, 4'h1});
    step(5'h08, 30);
    chk({6'h0, st.mode}, {6'h0, 4'h2});
    prot <= 2'h2;
    step(5'h10, 30);
    chk({9'h0, st.menu_open}, 10'h0);
    prot <= 2'h0;
    // edit, then let it commit by idle time
    step(5'h02, 3);
    repeat (60) @(posedge ref_clk_i);
    chk(10'(n_inc), 10'd1);
    chk(10'(n_cmt), 10'd1);
    // edit, then commit by the mode key before idle expiry
    step(5'h02, 3);
    step(5'h04, 3);
    chk(10'(n_cmt), 10'd2);
    chk({6'h0, st.param_idx}, 10'h1);
    repeat (4) step(5'h04, 3);
    chk({6'h0, st.param_idx}, 10'h0);
    chk(10'(n_cmt), 10'd2);
    // a down edit during the auto/manual hold is committed by the mode change, before idle expiry
    op.push(5'h09, 24);
    repeat (2) @(posedge ref_clk_i);
    chk({6'h0, st.mode}, {6'h0, 4'h1});
    chk(10'(n_cmt), 10'd3);
    chk(10'(n_dec), 10'd1);
    // manual: up/down move the manipulated variable, not parameters
    step(5'h02, 3);
    step(5'h01, 3);
    chk(10'(n_mvi), 10'd1);
    chk(10'(n_mvd), 10'd1);
    chk(10'(n_inc), 10'd2);
    chk(10'(n_cmt), 10'd3);
    step(5'h08, 30);
    // level 0 locked: stepping down from level 1 skips it and wraps to calibration
    prot <= 2'h1;
    step(5'h10, 30);
    step(5'h02, 3);
    step(5'h01, 3);
    chk({6'h0, st.menu_sel}, {6'h0, 4'h8});
    step(5'h04, 3);
    prot <= 2'h0;
    chk({st.mode, st.menu_open, st.control_reset, 4'h0}, {4'h8, 1'b0, 1'b1, 4'h0});
    // voltage input with the transfer unit fitted
    xfer  <= 1'b1;
    itype <= 2'h3;
    cal_pulse(1'b1, 1'b0, 3'h4);
    cal_pulse(1'b1, 1'b0, 3'h0);
    cal_pulse(1'b0, 1'b1, 3'h0);
    chk({3'h0, cprov}, 10'h010);
    chk(10'(n_cc), 10'd0);
    cal_pulse(1'b1, 1'b0, 3'h5);
    cal_pulse(1'b1, 1'b0, 3'h6);
    cal_pulse(1'b0, 1'b1, 3'h0);
    chk({2'h0, cdone, cprov}, 10'h080);
    chk(10'(n_cc), 10'd1);
    // no transfer unit: its item is refused; a thermocouple needs both of its items
    xfer  <= 1'b0;
    itype <= 2'h0;
    cal_pulse(1'b1, 1'b0, 3'h6);
    chk({3'h0, cprov}, 10'h000);
    cal_pulse(1'b1, 1'b0, 3'h0);
    cal_pulse(1'b0, 1'b1, 3'h0);
    chk(10'(n_cc), 10'd1);
    cal_pulse(1'b1, 1'b0, 3'h1);
    cal_pulse(1'b0, 1'b1, 3'h0);
    chk(10'(n_cc), 10'd2);
    // reset in mid-run returns the mode to level 0 and clears the calibrated flag
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    chk({st.mode, cdone, st.control_reset, st.param_idx}, {4'h2, 1'b0, 1'b0, 4'h0});
    final_report();
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk_i);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
